//--- core/rrs_exec.sv
// Execution datapath for return-literal, rotates and subtract-literal
`timescale 1ns/1ps
`default_nettype none

module rrs_exec
    import rrs_pkg::*;
#(
    parameter int PC_W = RRS_PC_W_DEF
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rstn,
    // Instruction issue
    input wire logic i_op_valid,
    input wire rrs_op_type i_op,
    input wire logic [7:0] i_literal,
    input wire logic [6:0] i_file_addr,
    input wire logic i_dest,
    output logic o_ready,
    output logic o_done,
    // File register access
    input wire logic [7:0] i_file_rdata,
    output logic o_file_we,
    output logic [6:0] o_file_addr,
    output logic [7:0] o_file_wdata,
    // Stack and program counter
    input wire logic [PC_W-1:0] i_stack_top,
    output logic o_stack_pop,
    output logic [PC_W-1:0] o_pc,
    // Core state
    output logic [7:0] o_w,
    output logic o_carry,
    output logic o_nibble_carry,
    output logic o_zero
);

    // ********************************************
    // Parameter check
    // ********************************************
    if (PC_W < 1 || PC_W > RRS_PC_W_MAX) begin : g_bad_pc
        $error("rrs_exec: PC_W out of range");
    end

    // ********************************************
    // Reset release
    // ********************************************
    logic rst_meta_r;
    logic rst_n_r;

    // Assert at once, release after two edges
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // ********************************************
    // Declarations
    // ********************************************
    rrs_state_type state_r;
    rrs_state_type state_nxt;
    logic [7:0] w_r;
    logic [7:0] w_nxt;
    logic carry_r;
    logic carry_nxt;
    logic nib_r;
    logic nib_nxt;
    logic zero_r;
    logic zero_nxt;
    logic [PC_W-1:0] pc_r;
    logic [PC_W-1:0] pc_nxt;
    logic pop_r;
    logic pop_nxt;
    logic done_r;
    logic done_nxt;
    logic fwe_r;
    logic fwe_nxt;
    logic [6:0] fadr_r;
    logic [6:0] fadr_nxt;
    logic [7:0] fwd_r;
    logic [7:0] fwd_nxt;
    logic accept;
    logic is_rot;

    rrs_alu_if alu_bus ();

    // ********************************************
    // Arithmetic unit
    // ********************************************
    rrs_alu u_alu (
        .bus (alu_bus.alu)
    );

    // Rotates work on the file register, the rest on the literal
    assign is_rot = (i_op == rotate_left_carry_op) || (i_op == rotate_right_carry_op);
    assign alu_bus.op = i_op;
    assign alu_bus.opnd = is_rot ? i_file_rdata : i_literal;
    assign alu_bus.w_val = w_r;
    assign alu_bus.carry_in = carry_r;

    // ********************************************
    // Issue handshake
    // ********************************************
    // Held off during reset and during the return flush cycle
    assign o_ready = rst_n_r && (state_r == st_idle);
    assign accept = i_op_valid && o_ready;

    // ********************************************
    // Sequencer
    // ********************************************
    // Return needs a second cycle to refill after the jump
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            st_idle: begin
                if (accept && i_op == return_with_literal_op) begin
                    state_nxt = st_flush;
                end
            end
            st_flush: begin
                state_nxt = st_idle;
            end
            default: begin
                state_nxt = st_idle;
            end
        endcase
    end

    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= st_idle;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ********************************************
    // Datapath next state
    // ********************************************
    // W, flags, pc and file address and data hold unless the accepted operation says otherwise; pop, file write and done are one-cycle pulses
    always_comb begin
        w_nxt = w_r;
        carry_nxt = carry_r;
        nib_nxt = nib_r;
        zero_nxt = zero_r;
        pc_nxt = pc_r;
        pop_nxt = 1'b0;
        fwe_nxt = 1'b0;
        fadr_nxt = fadr_r;
        fwd_nxt = fwd_r;
        done_nxt = (state_r == st_flush);
        if (accept) begin
            case (i_op)
                return_with_literal_op: begin
                    w_nxt = alu_bus.result;
                    pc_nxt = i_stack_top;
                    pop_nxt = 1'b1;
                end
                rotate_left_carry_op, rotate_right_carry_op: begin
                    carry_nxt = alu_bus.carry_out;
                    done_nxt = 1'b1;
                    if (i_dest) begin
                        fwe_nxt = 1'b1;
                        fadr_nxt = i_file_addr;
                        fwd_nxt = alu_bus.result;
                    end else begin
                        w_nxt = alu_bus.result;
                    end
                end
                subtract_from_literal_op: begin
                    w_nxt = alu_bus.result;
                    carry_nxt = alu_bus.carry_out;
                    nib_nxt = alu_bus.nib_out;
                    zero_nxt = alu_bus.zero_out;
                    done_nxt = 1'b1;
                end
                default: begin
                    done_nxt = 1'b0;
                end
            endcase
        end
    end

    // ********************************************
    // Datapath registers
    // ********************************************
    always_ff @(posedge i_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            w_r <= RRS_W_RST;
            carry_r <= RRS_FLAG_RST;
            nib_r <= RRS_FLAG_RST;
            zero_r <= RRS_FLAG_RST;
            pc_r <= '0;
            pop_r <= 1'b0;
            fwe_r <= 1'b0;
            fadr_r <= 7'h00;
            fwd_r <= 8'h00;
            done_r <= 1'b0;
        end else begin
            w_r <= w_nxt;
            carry_r <= carry_nxt;
            nib_r <= nib_nxt;
            zero_r <= zero_nxt;
            pc_r <= pc_nxt;
            pop_r <= pop_nxt;
            fwe_r <= fwe_nxt;
            fadr_r <= fadr_nxt;
            fwd_r <= fwd_nxt;
            done_r <= done_nxt;
        end
    end

    // Outputs straight from flops
    assign o_w = w_r;
    assign o_carry = carry_r;
    assign o_nibble_carry = nib_r;
    assign o_zero = zero_r;
    assign o_pc = pc_r;
    assign o_stack_pop = pop_r;
    assign o_file_we = fwe_r;
    assign o_file_addr = fadr_r;
    assign o_file_wdata = fwd_r;
    assign o_done = done_r;

    // ********************************************
    // Checks
    // ********************************************
    ret_w_load_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        accept && i_op == return_with_literal_op |=>
        w_r == $past(i_literal) && $stable(carry_r)
        && $stable(nib_r) && $stable(zero_r))
        else $error("return did not load literal or moved a flag");

    ret_pop_pc_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        accept && i_op == return_with_literal_op |=>
        o_stack_pop && o_pc == $past(i_stack_top) ##1 !o_stack_pop)
        else $error("return did not pop stack into pc once");

    ret_two_cycle_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        accept && i_op == return_with_literal_op |=>
        (!o_ready && !o_done) ##1 (o_ready && o_done))
        else $error("return not two cycles");

    rotl_carry_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        accept && i_op == rotate_left_carry_op |=>
        o_done && o_ready && carry_r == $past(i_file_rdata[7])
        && $stable(zero_r) && $stable(nib_r))
        else $error("left rotate carry or timing wrong");

    rotl_dest_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        accept && i_op == rotate_left_carry_op |=>
        ($past(i_dest) ? (o_file_we && $stable(w_r)
        && o_file_wdata == {$past(i_file_rdata[6:0]), $past(carry_r)})
        : (!o_file_we
        && w_r == {$past(i_file_rdata[6:0]), $past(carry_r)})))
        else $error("left rotate destination wrong");

    rotr_dest_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        accept && i_op == rotate_right_carry_op |=>
        ($past(i_dest) ? (o_file_we && $stable(w_r)
        && o_file_wdata == {$past(carry_r), $past(i_file_rdata[7:1])})
        : (!o_file_we
        && w_r == {$past(carry_r), $past(i_file_rdata[7:1])})))
        else $error("right rotate destination wrong");

    rot_addr_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        accept && is_rot && i_dest |=>
        o_file_addr == $past(i_file_addr))
        else $error("rotate write address wrong");

    sub_result_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        accept && i_op == subtract_from_literal_op |=>
        w_r == 8'($past(i_literal) - $past(w_r)) && o_done)
        else $error("subtract result wrong");

    sub_carry_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        accept && i_op == subtract_from_literal_op |=>
        carry_r == ($past(w_r) <= $past(i_literal)))
        else $error("subtract carry wrong");

    sub_nibble_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        accept && i_op == subtract_from_literal_op |=>
        nib_r == ($past(w_r[3:0]) <= $past(i_literal[3:0])))
        else $error("subtract nibble carry wrong");

    rotr_carry_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        accept && i_op == rotate_right_carry_op |=>
        carry_r == $past(i_file_rdata[0]))
        else $error("right rotate carry wrong");

    sub_zero_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        accept && i_op == subtract_from_literal_op |=>
        zero_r == ($past(i_literal) == $past(w_r)))
        else $error("subtract zero flag wrong");

    flag_quiet_a: assert property (
        @(posedge i_clk) disable iff (!rst_n_r)
        !accept |=> $stable(carry_r) && $stable(w_r) && !o_file_we)
        else $error("state moved with no instruction");

endmodule // rrs_exec

`default_nettype wire

//--- core/rrs_pkg.sv
// Shared constants and types for the return/rotate/subtract datapath
package rrs_pkg;

    // ********************************************
    // Widths and field positions
    // ********************************************
    localparam int RRS_DATA_W = 8;
    localparam int RRS_ADDR_W = 7;
    localparam int RRS_PC_W_DEF = 15;
    localparam int RRS_PC_W_MAX = 16;
    localparam int RRS_MSB_POS = 7;
    localparam int RRS_NIB_MSB = 3;

    // ********************************************
    // Reset values
    // ********************************************
    localparam logic [7:0] RRS_W_RST = 8'h00;
    localparam logic RRS_FLAG_RST = 1'h0;

    // ********************************************
    // Cycle counts per instruction
    // ********************************************
    localparam int RRS_RET_CYCLES = 2;
    localparam int RRS_ROT_CYCLES = 1;
    localparam int RRS_SUB_CYCLES = 1;

    // ********************************************
    // Operations and sequencer states
    // ********************************************
    typedef enum logic [1:0] {
        return_with_literal_op,
        rotate_left_carry_op,
        rotate_right_carry_op,
        subtract_from_literal_op
    } rrs_op_type;

    typedef enum logic {
        st_idle,
        st_flush
    } rrs_state_type;

endpackage

//--- core/rrs_alu_if.sv
// Connection between the sequencer and the arithmetic unit
`timescale 1ns/1ps
`default_nettype none

interface rrs_alu_if;
    import rrs_pkg::*;

    // Operands
    rrs_op_type op;
    logic [7:0] opnd;
    logic [7:0] w_val;
    logic carry_in;
    // Results
    logic [7:0] result;
    logic carry_out;
    logic nib_out;
    logic zero_out;

    modport seq (output op, opnd, w_val, carry_in,
                 input result, carry_out, nib_out, zero_out);
    modport alu (input op, opnd, w_val, carry_in,
                 output result, carry_out, nib_out, zero_out);
endinterface

`default_nettype wire

//--- core/rrs_alu.sv
// Combinational rotate and subtract unit
`timescale 1ns/1ps
`default_nettype none

module rrs_alu
    import rrs_pkg::*;
(
    // Sequencer side
    rrs_alu_if.alu bus
);

    logic [8:0] diff;
    logic [4:0] ndiff;

    // ********************************************
    // Result and flag generation
    // ********************************************
    // Subtraction as opnd + ~w + 1 so carry means no borrow
    always_comb begin
        diff = {1'b0, bus.opnd} + {1'b0, ~bus.w_val} + 9'h001;
        ndiff = {1'b0, bus.opnd[RRS_NIB_MSB:0]}
              + {1'b0, ~bus.w_val[RRS_NIB_MSB:0]} + 5'h01;
        bus.result = bus.opnd;
        bus.carry_out = bus.carry_in;
        bus.nib_out = ndiff[4];
        case (bus.op)
            rotate_left_carry_op: begin
                bus.result = {bus.opnd[6:0], bus.carry_in};
                bus.carry_out = bus.opnd[RRS_MSB_POS];
            end
            rotate_right_carry_op: begin
                bus.result = {bus.carry_in, bus.opnd[7:1]};
                bus.carry_out = bus.opnd[0];
            end
            subtract_from_literal_op: begin
                bus.result = diff[7:0];
                bus.carry_out = diff[8];
            end
            default: begin
                bus.result = bus.opnd;
                bus.carry_out = bus.carry_in;
            end
        endcase
        bus.zero_out = (bus.result == 8'h00);
    end

endmodule // rrs_alu

`default_nettype wire

//--- test/rrs_exec_tb.sv
// Self-checking bench for the return/rotate/subtract datapath
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import rrs_pkg::*;

    // ********************************************
    // Clock, reset and design hookup
    // ********************************************
    localparam int PC_W = RRS_PC_W_DEF;
    logic i_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic i_op_valid = 1'b0;
    rrs_op_type i_op = return_with_literal_op;
    logic [7:0] i_literal = 8'h00;
    logic [6:0] i_file_addr = 7'h00;
    logic i_dest = 1'b0;
    logic [7:0] i_file_rdata = 8'h00;
    logic [PC_W-1:0] i_stack_top = '0;
    logic o_ready, o_done, o_file_we, o_stack_pop, o_carry, o_nibble_carry, o_zero;
    logic [6:0] o_file_addr;
    logic [7:0] o_file_wdata, o_w;
    logic [PC_W-1:0] o_pc;
    // Reference state kept as plain integers
    int m_w, m_c, m_nib, m_z, m_pc, m_fa, m_fd, p_kind, p_we;
    int n_errors, compares, seed, i, r;

    // 25 MHz clock
    always #20 i_clk = ~i_clk;

    rrs_exec #(.PC_W(PC_W)) dut (
        .i_clk(i_clk), .i_rstn(i_rstn), .i_op_valid(i_op_valid), .i_op(i_op),
        .i_literal(i_literal), .i_file_addr(i_file_addr), .i_dest(i_dest),
        .o_ready(o_ready), .o_done(o_done), .i_file_rdata(i_file_rdata),
        .o_file_we(o_file_we), .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata),
        .i_stack_top(i_stack_top), .o_stack_pop(o_stack_pop), .o_pc(o_pc), .o_w(o_w),
        .o_carry(o_carry), .o_nibble_carry(o_nibble_carry), .o_zero(o_zero)
    );

    // ********************************************
    // Compare, report and verdict
    // ********************************************
    task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic finish_test();
        $display("checks %0d mismatches %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Model back to its reset state
    task automatic model_reset();
        m_w = 0;
        m_c = 0;
        m_nib = 0;
        m_z = 0;
        m_pc = 0;
        p_kind = -1;
    endtask

    // W, flags, pc and ready checked clear while reset is held
    task automatic check_reset();
        cmp("rst_w", 16'h0000, {8'h00, o_w});
        cmp("rst_flags", 16'h0000, {13'h0000, o_carry, o_nibble_carry, o_zero});
        cmp("rst_pc", 16'h0000, 16'(o_pc));
        cmp("rst_ready", 16'h0000, {15'h0000, o_ready});
    endtask

    // ********************************************
    // Reference model of one taken instruction
    // ********************************************
    task automatic model_take(input int op, input int lit, input int addr, input int dest,
                              input int rd, input int top);
        int res;
        int nc;
        p_we = 0;
        if (op == 0) begin
            m_w = lit;
            m_pc = top;
        end else if (op == 3) begin
            res = (lit - m_w) & 255;
            m_c = (m_w <= lit);
            m_nib = ((m_w & 15) <= (lit & 15));
            m_z = (res == 0);
            m_w = res;
        end else begin
            res = (op == 1) ? (((rd << 1) | m_c) & 255) : ((m_c << 7) | (rd >> 1));
            nc = (op == 1) ? ((rd >> 7) & 1) : (rd & 1);
            m_c = nc;
            if (dest != 0) begin
                p_we = 1;
                m_fa = addr;
                m_fd = res;
            end else begin
                m_w = res;
            end
        end
        p_kind = op;
    endtask

    // Outputs that follow the last taken instruction, one cycle on
    task automatic check_prev();
        if (p_kind >= 0) begin
            cmp("w", 16'(m_w), {8'h00, o_w});
            cmp("carry", 16'(m_c), {15'h0000, o_carry});
            cmp("nibble_carry", 16'(m_nib), {15'h0000, o_nibble_carry});
            cmp("zero", 16'(m_z), {15'h0000, o_zero});
            cmp("pc", 16'(m_pc), 16'(o_pc));
            cmp("file_we", 16'(p_we), {15'h0000, o_file_we});
            if (p_we != 0) begin
                cmp("file_addr", 16'(m_fa), {9'h000, o_file_addr});
                cmp("file_wdata", 16'(m_fd), {8'h00, o_file_wdata});
            end
            cmp("stack_pop", 16'(p_kind == 0), {15'h0000, o_stack_pop});
            if (p_kind == 0) begin
                // When called from issue the request is still held, so this edge also proves the refusal
                cmp("done_early", 16'h0000, {15'h0000, o_done});
                cmp("ready_flush", 16'h0000, {15'h0000, o_ready});
                @(posedge i_clk);
                #1;
                cmp("done", 16'h0001, {15'h0000, o_done});
                cmp("stack_pop_end", 16'h0000, {15'h0000, o_stack_pop});
            end else begin
                cmp("done", 16'h0001, {15'h0000, o_done});
            end
        end
        p_kind = -1;
    endtask

    // ********************************************
    // Issue one instruction, entered just after a rising edge
    // ********************************************
    task automatic issue(input int op, input int lit, input int addr, input int dest,
                         input int rd, input int top);
        int t;
        i_op_valid <= 1'b1;
        i_op <= rrs_op_type'(op[1:0]);
        i_literal <= lit[7:0];
        i_file_addr <= addr[6:0];
        i_dest <= dest[0];
        i_file_rdata <= rd[7:0];
        i_stack_top <= top[PC_W-1:0];
        #1;
        check_prev();
        // Bounded wait for the block to accept
        for (t = 0; t < 20 && o_ready !== 1'b1; t++) begin
            @(posedge i_clk);
            #1;
        end
        if (o_ready !== 1'b1) begin
            n_errors++;
            $display("mismatch ready expected 1 seen %b", o_ready);
            finish_test();
        end else begin
            @(posedge i_clk);
            model_take(op, lit & 255, addr & 127, dest & 1, rd & 255, top & ((1 << PC_W) - 1));
        end
    endtask

    // Release the request and check the last result
    task automatic drain();
        i_op_valid <= 1'b0;
        #1;
        check_prev();
        @(posedge i_clk);
    endtask

    // ********************************************
    // Main sequence
    // ********************************************
    initial begin
        n_errors = 0;
        compares = 0;
        seed = 32'had1e;
        model_reset();
        repeat (16) @(posedge i_clk);
        #1;
        check_reset();
        @(posedge i_clk);
        i_rstn <= 1'b1;
        // Rotate left 1110 0110 with carry clear, then subtract boundaries
        issue(1, 0, 127, 0, 8'hE6, 0);
        issue(3, 8'hCC, 0, 0, 0, 0);
        issue(3, 8'h0F, 0, 0, 0, 0);
        issue(3, 8'h10, 0, 0, 0, 0);
        issue(3, 8'h00, 0, 0, 0, 0);
        issue(2, 0, 0, 1, 8'h01, 0);
        issue(0, 8'h5A, 0, 0, 0, 32'h7FFF);
        issue(0, 8'hFF, 0, 0, 0, 32'h0001);
        issue(1, 0, 5, 1, 8'h80, 0);
        drain();
        $display("test directed done");
        // Random mix, back to back, with a reset in mid-run
        for (i = 0; i < 400; i++) begin
            if (i == 200) begin
                drain();
                i_rstn <= 1'b0;
                #1;
                check_reset();
                model_reset();
                repeat (3) @(posedge i_clk);
                i_rstn <= 1'b1;
            end
            r = $random(seed);
            issue(r & 3, r >> 2, r >> 10, r >> 17, r >> 18, $random(seed));
        end
        drain();
        $display("test random done");
        finish_test();
    end
endmodule // testbench

`default_nettype wire
